// ---- hw/i2c_status_flags.sv ----
// Behaviour
// - Master transmit: ack flag set on no-ack, cleared on ack, at ack end.
// - Transmit-active set at transmit start, cleared when slave ack ends.
// - Bus collision flag set on collision during a master operation.
// - Bus collision flag clears only by disabling then re-enabling the module.
// - General-call flag set on general call address, cleared at Stop.
// - Ten-bit flag set on second matching address byte, cleared at Stop.
// - Transmit write while busy is dropped and sets a sticky write-collision flag.
// - Overflow flag set when a byte completes with receive holding still full.
// - Overflow set at the attempted move to holding; software clears it.
// - Slave data/address flag cleared on address match, set on data byte.
// - Status bits 31..16 always read zero.
// - Status bits 13..11 always read zero.
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module i2c_status_flags
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Wishbone slave
    input  wire logic [isf_pkg::ADDR_W-1:0]  wb_adr_i,
    input  wire logic [isf_pkg::DATA_W-1:0]  wb_dat_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic                        wb_we_i,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    output logic      [isf_pkg::DATA_W-1:0]  wb_dat_o,
    output logic                             wb_ack_o,
    // Events from the two-wire engine
    input  wire logic                        master_tx_start_i,
    input  wire logic                        slave_ack_end_i,
    input  wire logic                        slave_nack_i,
    input  wire logic                        master_op_i,
    input  wire logic                        collision_i,
    input  wire logic                        stop_det_i,
    input  wire logic                        gc_match_i,
    input  wire logic                        ten_bit_match_i,
    input  wire logic                        slave_addr_match_i,
    input  wire logic                        slave_data_rx_i,
    input  wire logic                        rx_byte_done_i,
    input  wire logic [isf_pkg::BYTE_W-1:0]  rx_byte_i,
    input  wire logic                        busy_i,
    input  wire logic                        tx_take_i,
    // To the two-wire engine
    output logic                             module_on_o,
    output logic      [isf_pkg::BYTE_W-1:0]  tx_data_o,
    output logic                             tx_full_o
);

    typedef struct packed
    {
        logic                        on;
        logic                        ack_not_received;
        logic                        master_tx_active;
        logic                        data_not_address;
        logic [isf_pkg::BYTE_W-1:0]  tx_holding_reg;
        logic                        tx_full;
        logic [isf_pkg::BYTE_W-1:0]  rx_holding_reg;
        logic                        rx_full;
        logic [isf_pkg::DATA_W-1:0]  rdata;
    } isf_state_t;

    isf_state_t s;
    isf_state_t next_s;

    // Bus strobes
    logic                            bus_req;
    logic                            bus_wr;
    logic                            bus_rd;

    // Sticky flag vectors
    logic [isf_pkg::NUM_FLAGS-1:0]   flag_set;
    logic [isf_pkg::NUM_FLAGS-1:0]   flag_clr;
    logic [isf_pkg::NUM_FLAGS-1:0]   flag;

    // Decoded accesses
    logic                            wr_status;
    logic                            wr_control;
    logic                            wr_tx;
    logic                            rd_rx;
    logic                            tx_busy;
    logic                            rx_room;
    logic [isf_pkg::DATA_W-1:0]      status_word;

    // Register select on the current address
    function automatic logic hit(input logic [isf_pkg::ADDR_W-1:0] adr,
                                 input logic [isf_pkg::ADDR_W-1:0] off);
        hit = (adr == off);
    endfunction : hit

    // Bus handshake
    isf_wb_slave u_wb
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cyc_i (wb_cyc_i),
        .stb_i (wb_stb_i),
        .we_i  (wb_we_i),
        .ack_o (wb_ack_o),
        .req_o (bus_req),
        .wr_o  (bus_wr),
        .rd_o  (bus_rd)
    );

    // Write commits per register, low byte lane or high byte lane as needed
    assign wr_status  = bus_wr & hit(wb_adr_i, isf_pkg::OFF_STATUS) & wb_sel_i[0];
    assign wr_control = bus_wr & hit(wb_adr_i, isf_pkg::OFF_CONTROL) & wb_sel_i[1];
    assign wr_tx      = bus_wr & hit(wb_adr_i, isf_pkg::OFF_TX) & wb_sel_i[0];
    assign rd_rx      = bus_rd & hit(wb_adr_i, isf_pkg::OFF_RX);

    // Holding register still owned by the engine or a pending byte
    assign tx_busy = busy_i | s.tx_full;

    // Receive holding empty, or emptied by a read at this same edge
    assign rx_room = ~s.rx_full | rd_rx;

    // Set terms of the sticky flags
    always_comb
    begin
        flag_set                     = '0;
        flag_set[isf_pkg::FL_BCL]    = s.on & master_op_i & collision_i;
        flag_set[isf_pkg::FL_GC]     = s.on & gc_match_i;
        flag_set[isf_pkg::FL_TEN]    = s.on & ten_bit_match_i;
        flag_set[isf_pkg::FL_TX_WRITE_COLLISION]  = wr_tx & tx_busy;
        flag_set[isf_pkg::FL_OV]     = s.on & rx_byte_done_i & ~rx_room;
    end

    // Clear terms of the sticky flags
    always_comb
    begin
        flag_clr                     = '0;
        // Only a re-enable after a disable clears the collision flag
        flag_clr[isf_pkg::FL_BCL]    = wr_control & ~s.on
                                       & wb_dat_i[isf_pkg::CTRL_ON];
        flag_clr[isf_pkg::FL_GC]     = stop_det_i;
        flag_clr[isf_pkg::FL_TEN]    = stop_det_i;
        // Software clears by writing zero, a one leaves the bit
        flag_clr[isf_pkg::FL_TX_WRITE_COLLISION]  = wr_status
                                       & ~wb_dat_i[isf_pkg::ST_TX_WRITE_COLLISION];
        flag_clr[isf_pkg::FL_OV]     = wr_status
                                       & ~wb_dat_i[isf_pkg::ST_OV];
    end

    // One sticky cell per flag
    generate
        for (genvar g = 0; g < isf_pkg::NUM_FLAGS; g++)
        begin : g_flag
            isf_flag_cell u_cell
            (
                .clk_i  (clk_i),
                .rst_i  (rst_i),
                .set_i  (flag_set[g]),
                .clr_i  (flag_clr[g]),
                .flag_o (flag[g])
            );
        end
    endgenerate

    // Status word, unimplemented bits tied low
    always_comb
    begin
        status_word                       = isf_pkg::WORD_RST;
        status_word[isf_pkg::ST_ACK_NR]   = s.ack_not_received;
        status_word[isf_pkg::ST_MTX]      = s.master_tx_active;
        status_word[isf_pkg::ST_BCL]      = flag[isf_pkg::FL_BCL];
        status_word[isf_pkg::ST_GC]       = flag[isf_pkg::FL_GC];
        status_word[isf_pkg::ST_TEN]      = flag[isf_pkg::FL_TEN];
        status_word[isf_pkg::ST_TX_WRITE_COLLISION]    = flag[isf_pkg::FL_TX_WRITE_COLLISION];
        status_word[isf_pkg::ST_OV]       = flag[isf_pkg::FL_OV];
        status_word[isf_pkg::ST_DA]       = s.data_not_address;
        status_word[isf_pkg::ST_RBF]      = s.rx_full;
        status_word[isf_pkg::ST_TBF]      = s.tx_full;
    end

    // Next state of the block
    always_comb
    begin
        next_s = s;

        // Read data captured when a read request arrives, zero if unmapped
        if (bus_req & ~wb_we_i)
        begin
            next_s.rdata = isf_pkg::WORD_RST;
            if (hit(wb_adr_i, isf_pkg::OFF_STATUS))
                next_s.rdata = status_word;
            else if (hit(wb_adr_i, isf_pkg::OFF_CONTROL))
                next_s.rdata[isf_pkg::CTRL_ON] = s.on;
            else if (hit(wb_adr_i, isf_pkg::OFF_TX))
                next_s.rdata[isf_pkg::BYTE_W-1:0] = s.tx_holding_reg;
            else if (hit(wb_adr_i, isf_pkg::OFF_RX))
                next_s.rdata[isf_pkg::BYTE_W-1:0] = s.rx_holding_reg;
        end

        // Module on control
        if (wr_control)
            next_s.on = wb_dat_i[isf_pkg::CTRL_ON];

        // Master transmit status: active from start to end of slave ack
        if (s.on & master_tx_start_i)
            next_s.master_tx_active = 1'b1;
        else if (slave_ack_end_i)
            next_s.master_tx_active = 1'b0;

        // Acknowledge result updated at the end of the slave ack
        if (s.on & slave_ack_end_i)
            next_s.ack_not_received = slave_nack_i;

        // Slave byte kind: address match clears, data byte sets
        if (s.on & slave_addr_match_i)
            next_s.data_not_address = 1'b0;
        else if (s.on & slave_data_rx_i)
            next_s.data_not_address = 1'b1;

        // Transmit holding: a write while busy is dropped
        if (tx_take_i)
            next_s.tx_full = 1'b0;
        if (wr_tx & ~tx_busy)
        begin
            next_s.tx_holding_reg = wb_dat_i[isf_pkg::BYTE_W-1:0];
            next_s.tx_full        = 1'b1;
        end

        // Receive holding: a read frees it, a full one keeps the old byte
        if (rd_rx)
            next_s.rx_full = 1'b0;
        if (s.on & rx_byte_done_i & rx_room)
        begin
            next_s.rx_holding_reg = rx_byte_i;
            next_s.rx_full        = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s.on               <= isf_pkg::BIT_RST;
            s.ack_not_received <= isf_pkg::BIT_RST;
            s.master_tx_active <= isf_pkg::BIT_RST;
            s.data_not_address <= isf_pkg::BIT_RST;
            s.tx_holding_reg   <= isf_pkg::BYTE_RST;
            s.tx_full          <= isf_pkg::BIT_RST;
            s.rx_holding_reg   <= isf_pkg::BYTE_RST;
            s.rx_full          <= isf_pkg::BIT_RST;
            s.rdata            <= isf_pkg::WORD_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs
    assign wb_dat_o    = s.rdata;
    assign module_on_o = s.on;
    assign tx_data_o   = s.tx_holding_reg;
    assign tx_full_o   = s.tx_full;

endmodule : i2c_status_flags

// ---- hw/isf_pkg.sv ----
package isf_pkg;

    // Bus geometry
    localparam int          ADDR_W   = 4;
    localparam int          DATA_W   = 32;
    localparam int          BYTE_W   = 8;

    // Register byte offsets
    localparam logic [3:0]  OFF_STATUS  = 4'h0;
    localparam logic [3:0]  OFF_CONTROL = 4'h4;
    localparam logic [3:0]  OFF_TX      = 4'h8;
    localparam logic [3:0]  OFF_RX      = 4'hc;

    // Status field positions
    localparam int          ST_ACK_NR   = 15;
    localparam int          ST_MTX      = 14;
    localparam int          ST_BCL      = 10;
    localparam int          ST_GC       = 9;
    localparam int          ST_TEN      = 8;
    localparam int          ST_TX_WRITE_COLLISION    = 7;
    localparam int          ST_OV       = 6;
    localparam int          ST_DA       = 5;
    localparam int          ST_RBF      = 1;
    localparam int          ST_TBF      = 0;

    // Control field position
    localparam int          CTRL_ON     = 15;

    // Sticky flag slots
    localparam int          FL_BCL      = 0;
    localparam int          FL_GC       = 1;
    localparam int          FL_TEN      = 2;
    localparam int          FL_TX_WRITE_COLLISION    = 3;
    localparam int          FL_OV       = 4;
    localparam int          NUM_FLAGS   = 5;

    // Reset values
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam logic        BIT_RST     = 1'b0;

endpackage : isf_pkg

// ---- hw/isf_flag_cell.sv ----
`timescale 1ns/1ps
module isf_flag_cell
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);

    typedef struct packed
    {
        logic flag;
    } isf_cell_t;

    isf_cell_t s;
    isf_cell_t next_s;

    // Sticky bit, a set in the clear cycle wins
    always_comb
    begin
        next_s = s;
        if (set_i)
            next_s.flag = 1'b1;
        else if (clr_i)
            next_s.flag = 1'b0;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s <= '{flag: isf_pkg::BIT_RST};
        else
            s <= next_s;
    end

    assign flag_o = s.flag;

endmodule : isf_flag_cell

// ---- hw/isf_wb_slave.sv ----
`timescale 1ns/1ps
module isf_wb_slave
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic cyc_i,
    input  wire logic stb_i,
    input  wire logic we_i,
    output logic      ack_o,
    output logic      req_o,
    output logic      wr_o,
    output logic      rd_o
);

    typedef struct packed
    {
        logic ack;
    } isf_wb_t;

    isf_wb_t s;
    isf_wb_t next_s;

    // Answer one cycle after the request, drop ack the cycle after
    always_comb
    begin
        next_s     = s;
        next_s.ack = cyc_i & stb_i & ~s.ack;
    end

    // State register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s <= '{ack: isf_pkg::BIT_RST};
        else
            s <= next_s;
    end

    // New request edge, and commit strobes at the acked edge
    assign req_o = cyc_i & stb_i & ~s.ack;
    assign wr_o  = cyc_i & stb_i & s.ack & we_i;
    assign rd_o  = cyc_i & stb_i & s.ack & ~we_i;
    assign ack_o = s.ack;

endmodule : isf_wb_slave

// ---- test/isf_engine_model.sv ----
`timescale 1ns/1ps
module isf_engine_model
(
    input  wire logic        clk_i,
    output logic      [12:0] ev_o,
    output logic      [7:0]  byte_o
);
    // Quiet engine at time zero
    initial
    begin
        ev_o   = 13'h0000;
        byte_o = 8'h00;
    end
    // One-cycle event over held levels; a spent byte shows its inverse
    task automatic ev(input logic [12:0] lvl, input logic [12:0] p, input logic [7:0] b);
        @(posedge clk_i);
        ev_o   <= lvl | p;
        byte_o <= b;
        @(posedge clk_i);
        ev_o   <= lvl;
        byte_o <= ~b;
    endtask : ev
endmodule : isf_engine_model

// ---- test/isf_status_sva.sv ----
`timescale 1ns/1ps
module isf_sva_chk
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        collision_i,
    input wire logic        master_op_i,
    input wire logic        busy_i,
    input wire logic        tx_take_i,
    input wire logic        module_on_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_full_o
);
    logic bcl_m;
    logic st_rd;
    logic on_wr;
    logic tx_wr;
    // Decoded bus accesses at the ack cycle
    assign st_rd = wb_ack_o && !wb_we_i && wb_adr_i == isf_pkg::OFF_STATUS;
    assign on_wr = wb_ack_o && wb_we_i && wb_adr_i == isf_pkg::OFF_CONTROL && wb_sel_i[1];
    assign tx_wr = wb_ack_o && wb_we_i && wb_adr_i == isf_pkg::OFF_TX && wb_sel_i[0]
                   && !tx_take_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Expected bus collision flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            bcl_m <= 1'b0;
        else if (collision_i && master_op_i && module_on_o)
            bcl_m <= 1'b1;
        else if (on_wr && wb_dat_i[15] && !module_on_o)
            bcl_m <= 1'b0;
    end
    AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_HI_ZERO: assert property (st_rd |-> wb_dat_o[31:16] == 16'h0000)
        else $error("status upper half not zero");
    AST_MID_ZERO: assert property (st_rd |-> wb_dat_o[13:11] == 3'h0)
        else $error("status bits 13 to 11 not zero");
    AST_BCL: assert property (st_rd |-> wb_dat_o[10] == $past(bcl_m))
        else $error("bus collision flag wrong");
    AST_ON: assert property (on_wr |=> module_on_o == $past(wb_dat_i[15]))
        else $error("on bit not taken");
    AST_TX_LOAD: assert property (tx_wr && module_on_o && !busy_i && !tx_full_o
        |=> tx_full_o && tx_data_o == $past(wb_dat_i[7:0]))
        else $error("tx byte not loaded");
    AST_TX_KEEP: assert property (tx_wr && (busy_i || tx_full_o)
        |=> $stable(tx_data_o) && $stable(tx_full_o))
        else $error("refused tx write changed holding");
endmodule : isf_sva_chk
bind i2c_status_flags isf_sva_chk isf_sva_chk_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .collision_i,
    .master_op_i, .busy_i, .tx_take_i, .module_on_o, .tx_data_o, .tx_full_o);

// ---- test/i2c_status_flags_bench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module i2c_status_flags_bench;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [3:0]  wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o, got, exp_v;
    logic        wb_ack_o, module_on_o, tx_full_o;
    logic [12:0] ev;
    logic [7:0]  rxb, txd, b1, b2;
    logic [31:0] q_m[$], q_e[$];
    logic [31:0] seed = 32'hee01e730;
    int          error_cnt = 0;
    int          n_compared = 0;
    i2c_status_flags i2c_status_flags_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
        .master_tx_start_i(ev[0]), .slave_ack_end_i(ev[1]), .slave_nack_i(ev[2]),
        .master_op_i(ev[3]), .collision_i(ev[4]), .stop_det_i(ev[5]), .gc_match_i(ev[6]),
        .ten_bit_match_i(ev[7]), .slave_addr_match_i(ev[8]), .slave_data_rx_i(ev[9]),
        .rx_byte_done_i(ev[10]), .rx_byte_i(rxb), .tx_take_i(ev[11]), .busy_i(ev[12]),
        .module_on_o, .tx_data_o(txd), .tx_full_o);
    isf_engine_model isf_engine_model_i (.clk_i, .ev_o(ev), .byte_o(rxb));
    // 40 MHz clock
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    // Classic single Wishbone cycle, held until ack
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, w, d, 2'b11};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        q_m.push_back(m);
        q_e.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic ev_(input logic [12:0] l, input logic [12:0] p, input logic [7:0] b);
        isf_engine_model_i.ev(l, p, b);
    endtask : ev_
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // Read results against the oldest note
    always @(posedge clk_i)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && q_e.size() > 0)
        begin
            got = wb_dat_o & q_m.pop_front();
            exp_v = q_e.pop_front();
            `CHK(got, exp_v)
        end
    end
    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'hffffffff, 32'h0);
        rd(4'h4, 32'hffffffff, 32'h0);
        rd(4'h2, 32'hffffffff, 32'h0);
        $display("reset test done");
        ev_(13'h0, 13'h018, 8'h00);
        rd(4'h0, 32'h400, 32'h0);
        bus(4'h4, 1'b1, 32'h8000);
        ev_(13'h0, 13'h018, 8'h00);
        rd(4'h0, 32'h400, 32'h400);
        bus(4'h0, 1'b1, 32'h0);
        bus(4'h4, 1'b1, 32'h8000);
        rd(4'h0, 32'h400, 32'h400);
        bus(4'h4, 1'b1, 32'h0);
        bus(4'h4, 1'b1, 32'h8000);
        rd(4'h0, 32'h400, 32'h0);
        rd(4'h4, 32'h8000, 32'h8000);
        $display("collision test done");
        ev_(13'h0, 13'h001, 8'h00);
        rd(4'h0, 32'hc000, 32'h4000);
        ev_(13'h0, 13'h006, 8'h00);
        rd(4'h0, 32'hc000, 32'h8000);
        ev_(13'h0, 13'h001, 8'h00);
        ev_(13'h0, 13'h002, 8'h00);
        rd(4'h0, 32'hc000, 32'h0);
        ev_(13'h0, 13'h0c0, 8'h00);
        rd(4'h0, 32'h300, 32'h300);
        bus(4'h0, 1'b1, 32'h0);
        rd(4'h0, 32'h300, 32'h300);
        ev_(13'h0, 13'h020, 8'h00);
        rd(4'h0, 32'h300, 32'h0);
        ev_(13'h0, 13'h200, 8'h00);
        rd(4'h0, 32'h20, 32'h20);
        ev_(13'h0, 13'h100, 8'h00);
        rd(4'h0, 32'h20, 32'h0);
        $display("transfer status test done");
        b1 = xs();
        b2 = b1 ^ (xs() | 8'h01);
        ev_(13'h0, 13'h400, b1);
        rd(4'h0, 32'h42, 32'h2);
        ev_(13'h0, 13'h400, b2);
        rd(4'h0, 32'h42, 32'h42);
        rd(4'hc, 32'hff, {24'h0, b1});
        bus(4'h0, 1'b1, 32'h40);
        rd(4'h0, 32'h42, 32'h40);
        bus(4'h0, 1'b1, 32'h0);
        rd(4'h0, 32'h40, 32'h0);
        $display("overflow test done");
        ev_(13'h1000, 13'h0, 8'h00);
        bus(4'h8, 1'b1, {24'h0, b1});
        rd(4'h0, 32'h81, 32'h80);
        ev_(13'h0, 13'h0, 8'h00);
        bus(4'h0, 1'b1, 32'h80);
        rd(4'h0, 32'h80, 32'h80);
        bus(4'h0, 1'b1, 32'h0);
        bus(4'h8, 1'b1, {24'h0, b2});
        rd(4'h0, 32'h81, 32'h1);
        `CHK(txd, b2)
        bus(4'h8, 1'b1, {24'h0, b1});
        rd(4'h0, 32'h81, 32'h81);
        `CHK(txd, b2)
        rd(4'h8, 32'hff, {24'h0, b2});
        ev_(13'h0, 13'h800, 8'h00);
        rd(4'h0, 32'h1, 32'h0);
        $display("write collision test done");
        ev_(13'h0, 13'h0d9, 8'h00);
        rd(4'h0, 32'h4700, 32'h4700);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'hffffffff, 32'h0);
        rd(4'h4, 32'hffffffff, 32'h0);
        $display("mid-run reset test done");
        repeat (3) @(posedge clk_i);
        if (q_e.size() != 0)
            error_cnt++;
        results();
    end
endmodule : i2c_status_flags_bench
